/* File: bfv_pkg.sv */
package bfv_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_NS = 5;            // 200 MHz hclk
  localparam int unsigned CURRENT_LIMIT_SET_NS = 9_000_000;   // 9 ms latch-off delay
  localparam int unsigned CURRENT_LIMIT_SET_CYC = CURRENT_LIMIT_SET_NS / CLK_NS;
  localparam int unsigned KEEP_NS = 400;         // Code skew keep-out
  localparam int unsigned KEEP_CYC = (KEEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned MASK_NS = 100_000;     // 100 us mask
  localparam int unsigned MASK_CYC = MASK_NS / CLK_NS;
  localparam int unsigned FAST_NS = 1_000;       // 1 us per code step
  localparam int unsigned FAST_CYC = FAST_NS / CLK_NS;
  localparam int unsigned SLOW_NS = 4_000;       // 4 us per code step
  localparam int unsigned SLOW_CYC = SLOW_NS / CLK_NS;
  // ----------------------------------------------------------------
  // Code decode, target in units of 0.1 mV
  // ----------------------------------------------------------------
  localparam logic [15:0] CODE_TOP_MV10 = 16'h3A98;  // 1.5000 V
  localparam logic [15:0] CODE_STEP_MV10 = 16'h007D; // 12.5 mV
  localparam logic [3:0] CODE_OFF_HI = 4'hF;          // Zero-volt codes
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CODE = 8'h08;
  localparam int CTRL_SLOW_BIT = 0;
  localparam logic CTRL_RESET = 1'b0;
  localparam int ST_CURRENT_LIMIT_SET_LATCH = 0;
  localparam int ST_OVP_LATCH = 1;
  localparam int ST_RVP = 2;
  localparam int ST_SHUTDOWN = 3;
  localparam int ST_THROTTLE = 4;
  localparam int ST_TRANSIT = 5;
  localparam int ST_MASK = 6;
  localparam int ST_SEC_CURRENT_LIMIT_SET = 7;
  localparam int CODE_REF_LSB = 8;
  localparam int CODE_MV_LSB = 16;
  // Pins from comparators and the processor, all asynchronous
  typedef struct packed {
    logic [6:0] voltage_code;    // Requested code
    logic deep_sleep_req;        // High selects slow stepping
    logic single_phase_req;      // System phase-mode request
    logic enable;                // Enable pin
    logic supply_ok;             // Supply above upper lockout level
    logic current_limit_set_cmp;              // Current limit condition
    logic ovp_cmp;               // Output above 1.7 V
    logic rvp_below;             // Sense below -300 mV
    logic rvp_above;             // Sense above -100 mV
    logic tt_grounded;           // Thermal sense held at ground
    logic tt_hot;                // Thermal comparator, hysteresis
    logic out_low_cmp;           // Output below 200 mV
  } bfv_pins_t;
endpackage : bfv_pkg

/* File: bfv_sync.sv */
`timescale 1ns/1ps
module bfv_sync #(
  parameter int W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // ----------------------------------------------------------------
  // Three-stage capture, change taken once stages two and three agree
  // ----------------------------------------------------------------
  logic [W-1:0] s1_ff; // Metastable stage, read by s2 only
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;

  // Shift chain
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Per-bit agreement filter, rejects single-cycle glitches
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        q[i] <= 1'b0;
      end else if (s2_ff[i] == s3_ff[i]) begin
        q[i] <= s3_ff[i];
      end
    end
  end
endmodule : bfv_sync

/* File: bfv_supervisor.sv */
`timescale 1ns/1ps
// Summary of operation
// - Latch off after 9 ms current limit
// - Latches clear only by supply/enable recycle
// - Startup below 200 mV clamps secondary limit
// - New code ignored for 400 ns
// - Each code change restarts mask timer
// - Force multi-phase during code transitions
// - Overvoltage: PWM low, drivers both high
// - Overvoltage trip latches off until recycle
// - Grounded thermal sense disables overvoltage trip
// - Reverse voltage off below -300, on -100
// - Reverse monitor stays alive during overvoltage latch
// - Switch only with supply good, enable high
// - Shutdown: PWM low, discharge, drivers low
// - Throttle output follows thermal comparator
// - Code zero 1.5 V, 12.5 mV per step
// - Mask timer runs 100 us
// - Reference steps 1 us fast, 4 us slow
// - Deep-sleep request selects slow rate
module bfv_supervisor
  import bfv_pkg::*;
#(
  parameter int unsigned CURRENT_LIMIT_SET_CYCLES = CURRENT_LIMIT_SET_CYC,
  parameter int unsigned MASK_CYCLES = MASK_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire bfv_pins_t pin_in,
  output logic pwm_enable,
  output logic low_side_mode_n,
  output logic driver_off_n,
  output logic ss_discharge,
  output logic sec_current_limit_set_clamp,
  output logic force_multi_phase,
  output logic thermal_throttle_out,
  output logic output_ok_mask,
  output logic [6:0] ref_code
);
  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  bfv_pins_t pin_s; // Pins after three-stage filter
  // All asynchronous inputs pass the filter before use
  bfv_sync #(.W($bits(bfv_pins_t))) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(pin_in),
    .q(pin_s)
  );

  // ----------------------------------------------------------------
  // Run state and fault latches
  // ----------------------------------------------------------------
  logic shutdown; // Supply low or enable low
  logic current_limit_set_latch_ff; // Current-limit latch-off
  logic ovp_latch_ff; // Overvoltage latch-off
  logic rvp_ff; // Reverse-voltage state with hysteresis
  logic startup_ff; // Output not yet above 200 mV
  logic [20:0] current_limit_set_cnt_ff; // Persistence of current limit
  logic ovp_trip; // Overvoltage, unless thermal sense grounded
  logic ctrl_slow_ff; // Software-forced slow stepping
  assign shutdown = !(pin_s.supply_ok && pin_s.enable);
  assign ovp_trip = pin_s.ovp_cmp && !pin_s.tt_grounded;
  // Limit timer; any drop of the condition starts it over
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      current_limit_set_cnt_ff <= '0;
    end else if (shutdown || !pin_s.current_limit_set_cmp) begin
      current_limit_set_cnt_ff <= '0;
    end else if (current_limit_set_cnt_ff != 21'(CURRENT_LIMIT_SET_CYCLES)) begin
      current_limit_set_cnt_ff <= current_limit_set_cnt_ff + 21'h00_0001;
    end
  end
  // Latches only clear in shutdown, i.e. an enable or supply recycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      current_limit_set_latch_ff <= 1'b0;
    end else if (shutdown) begin
      current_limit_set_latch_ff <= 1'b0;
    end else if (current_limit_set_cnt_ff == 21'(CURRENT_LIMIT_SET_CYCLES)) begin
      current_limit_set_latch_ff <= 1'b1;
    end
  end

  // Overvoltage latch, same recycle path
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovp_latch_ff <= 1'b0;
    end else if (shutdown) begin
      ovp_latch_ff <= 1'b0;
    end else if (ovp_trip) begin
      ovp_latch_ff <= 1'b1;
    end
  end

  // Reverse-voltage hysteresis, kept alive in every running state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rvp_ff <= 1'b0;
    end else if (shutdown) begin
      rvp_ff <= 1'b0;
    end else if (pin_s.rvp_below) begin
      rvp_ff <= 1'b1;
    end else if (pin_s.rvp_above) begin
      rvp_ff <= 1'b0;
    end
  end

  // Startup window ends when output first rises past 200 mV
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      startup_ff <= 1'b1;
    end else if (shutdown) begin
      startup_ff <= 1'b1;
    end else if (!pin_s.out_low_cmp) begin
      startup_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Code tracking
  // ----------------------------------------------------------------
  logic [6:0] seen_code_ff; // Last code observed on the pins
  logic [6:0] target_ff; // Code accepted after keep-out
  logic [6:0] ref_ff; // Stepped reference
  logic [6:0] keep_cnt_ff; // Keep-out countdown
  logic pend_ff; // New code waiting out keep-out
  logic [14:0] mask_cnt_ff; // Output-ok mask countdown
  logic [9:0] step_cnt_ff; // Cycles since last reference step
  logic code_chg; // Pins differ from last seen code
  logic slow_rate; // Slow stepping selected
  logic [9:0] step_len; // Cycles per reference step
  logic transit; // Code transition in progress
  logic [15:0] target_mv10; // Decoded target
  assign code_chg = pin_s.voltage_code != seen_code_ff;
  assign slow_rate = pin_s.deep_sleep_req || ctrl_slow_ff;
  assign step_len = slow_rate ? 10'(SLOW_CYC) : 10'(FAST_CYC);
  assign transit = pend_ff || (ref_ff != target_ff);
  // Decode: top four bits all ones give zero volts
  always_comb begin
    if (target_ff[6:3] == CODE_OFF_HI) begin
      target_mv10 = '0;
    end else begin
      target_mv10 = 16'(CODE_TOP_MV10 - 16'(target_ff) * CODE_STEP_MV10);
    end
  end

  // Detect change, hold off, then accept the settled code
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen_code_ff <= '0;
      target_ff <= '0;
      keep_cnt_ff <= '0;
      pend_ff <= 1'b0;
    end else if (code_chg) begin
      seen_code_ff <= pin_s.voltage_code;
      keep_cnt_ff <= 7'(KEEP_CYC);
      pend_ff <= 1'b1;
    end else if (keep_cnt_ff != 7'h00) begin
      keep_cnt_ff <= keep_cnt_ff - 7'h01;
    end else if (pend_ff) begin
      target_ff <= seen_code_ff;
      pend_ff <= 1'b0;
    end
  end

  // Mask timer restarts on every detected change
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_cnt_ff <= '0;
    end else if (code_chg) begin
      mask_cnt_ff <= 15'(MASK_CYCLES);
    end else if (mask_cnt_ff != 15'h0000) begin
      mask_cnt_ff <= mask_cnt_ff - 15'h0001;
    end
  end

  // Reference walks one code per step period toward the target
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_ff <= '0;
      step_cnt_ff <= '0;
    end else if (ref_ff == target_ff) begin
      step_cnt_ff <= '0;
    end else if (step_cnt_ff >= step_len - 10'h001) begin
      step_cnt_ff <= '0;
      ref_ff <= (ref_ff < target_ff) ? ref_ff + 7'h01
                                     : ref_ff - 7'h01;
    end else begin
      step_cnt_ff <= step_cnt_ff + 10'h001;
    end
  end

  // ----------------------------------------------------------------
  // Output stage, every pin from a flip-flop
  // ----------------------------------------------------------------
  // Priority: shutdown, reverse voltage, crowbar, limit latch, run.
  // Reverse voltage beats crowbar so a negative rail turns all FETs off.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwm_enable <= 1'b0;
      low_side_mode_n <= 1'b0;
      driver_off_n <= 1'b0;
      ss_discharge <= 1'b1;
    end else if (shutdown) begin
      pwm_enable <= 1'b0;
      low_side_mode_n <= 1'b0;
      driver_off_n <= 1'b0;
      ss_discharge <= 1'b1;
    end else if (rvp_ff || pin_s.rvp_below) begin
      pwm_enable <= 1'b0;
      low_side_mode_n <= 1'b0;
      driver_off_n <= 1'b0;
      ss_discharge <= 1'b0;
    end else if (ovp_latch_ff || ovp_trip) begin
      pwm_enable <= 1'b0;
      low_side_mode_n <= 1'b1;
      driver_off_n <= 1'b1;
      ss_discharge <= 1'b0;
    end else if (current_limit_set_latch_ff) begin
      pwm_enable <= 1'b0;
      low_side_mode_n <= 1'b0;
      driver_off_n <= 1'b0;
      ss_discharge <= 1'b0;
    end else begin
      pwm_enable <= 1'b1;
      low_side_mode_n <= 1'b1;
      driver_off_n <= 1'b1;
      ss_discharge <= 1'b0;
    end
  end

  // Mode, clamp, throttle and tracking outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sec_current_limit_set_clamp <= 1'b0;
      force_multi_phase <= 1'b0;
      thermal_throttle_out <= 1'b0;
      output_ok_mask <= 1'b0;
      ref_code <= '0;
    end else begin
      sec_current_limit_set_clamp <= !shutdown && startup_ff
                        && pin_s.out_low_cmp;
      // Phase request ignored while a transition runs
      force_multi_phase <= transit || !pin_s.single_phase_req;
      thermal_throttle_out <= pin_s.tt_hot;
      output_ok_mask <= code_chg || (mask_cnt_ff > 15'h0001);
      ref_code <= ref_ff;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave, one wait state on every transfer
  // ----------------------------------------------------------------
  logic dph_ff; // Data phase pending
  logic dwr_ff; // Pending transfer is a write
  logic [7:0] dadr_ff; // Pending word address
  logic [31:0] rd_mux; // Read data selected by address
  // Address phase capture; hreadyout low for the first data cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_ff <= 1'b0;
      dwr_ff <= 1'b0;
      dadr_ff <= '0;
      hreadyout <= 1'b1;
    end else if (!dph_ff && hsel && htrans[1] && hready) begin
      dph_ff <= 1'b1;
      dwr_ff <= hwrite;
      dadr_ff <= haddr[7:0];
      hreadyout <= 1'b0;
    end else begin
      dph_ff <= 1'b0;
      hreadyout <= 1'b1;
    end
  end
  // Read mux; unmapped words read zero
  always_comb begin
    rd_mux = '0;
    unique case (dadr_ff)
      REG_CTRL: rd_mux[CTRL_SLOW_BIT] = ctrl_slow_ff;
      REG_STATUS: begin
        rd_mux[ST_CURRENT_LIMIT_SET_LATCH] = current_limit_set_latch_ff;
        rd_mux[ST_OVP_LATCH] = ovp_latch_ff;
        rd_mux[ST_RVP] = rvp_ff;
        rd_mux[ST_SHUTDOWN] = shutdown;
        rd_mux[ST_THROTTLE] = pin_s.tt_hot;
        rd_mux[ST_TRANSIT] = transit;
        rd_mux[ST_MASK] = mask_cnt_ff != 15'h0000;
        rd_mux[ST_SEC_CURRENT_LIMIT_SET] = startup_ff && pin_s.out_low_cmp;
      end
      REG_CODE: begin
        rd_mux[6:0] = target_ff;
        rd_mux[CODE_REF_LSB +: 7] = ref_ff;
        rd_mux[CODE_MV_LSB +: 16] = target_mv10;
      end
      default: rd_mux = '0;
    endcase
  end

  // Data phase: write control or load read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_slow_ff <= CTRL_RESET;
      hrdata <= '0;
      hresp <= 1'b0;
    end else if (dph_ff) begin
      hresp <= 1'b0;
      if (dwr_ff && dadr_ff == REG_CTRL) begin
        ctrl_slow_ff <= hwdata[CTRL_SLOW_BIT];
      end
      hrdata <= dwr_ff ? 32'h0000_0000 : rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb_chk @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_chg;
    code_chg;
  endsequence
  a_current_limit_set_latch_set: assert property (
    (!shutdown && current_limit_set_cnt_ff == 21'(CURRENT_LIMIT_SET_CYCLES)) |=> current_limit_set_latch_ff)
    else $error("current limit did not latch off");
  a_current_limit_set_restart: assert property (
    (!pin_s.current_limit_set_cmp && !current_limit_set_latch_ff) |=> current_limit_set_cnt_ff == 21'h00_0000)
    else $error("limit timer not restarted");
  a_latch_hold: assert property (
    (ovp_latch_ff && !shutdown) |=> ovp_latch_ff)
    else $error("overvoltage latch dropped without recycle");
  a_ovp_crowbar: assert property (
    (ovp_latch_ff && !shutdown && !rvp_ff && !pin_s.rvp_below)
      |=> !pwm_enable && low_side_mode_n && driver_off_n)
    else $error("crowbar outputs wrong");
  a_rvp_off: assert property (
    rvp_ff |=> !pwm_enable && !low_side_mode_n && !driver_off_n)
    else $error("reverse voltage did not turn drivers off");
  a_shutdown_out: assert property (
    shutdown |=> !pwm_enable && ss_discharge && !driver_off_n)
    else $error("shutdown outputs wrong");
  a_keepout_hold: assert property (s_chg |=> $stable(target_ff) [*8])
    else $error("code accepted inside keep-out");
  a_mask_restart: assert property (
    s_chg |=> mask_cnt_ff == 15'(MASK_CYCLES) ##1 output_ok_mask)
    else $error("mask timer not restarted");
  a_force_mp: assert property (pend_ff |=> force_multi_phase)
    else $error("multi-phase not forced in transition");
  a_ref_step: assert property ($changed(ref_ff) |->
    (ref_ff - $past(ref_ff) == 7'h01) || ($past(ref_ff) - ref_ff == 7'h01))
    else $error("reference moved more than one code");
endmodule : bfv_supervisor

/* File: bfv_cpu_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Processor side: walks the voltage code toward a destination
// ----------------------------------------------------------------
module bfv_cpu_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [6:0] dest,
  input wire logic [15:0] gap,
  output logic [6:0] voltage_code,
  output logic busy
);
  logic [6:0] code_ff; // Code now on the pins
  logic [15:0] wait_ff; // Cycles left before the next step
  // Code stepping; held at ground during reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      code_ff <= 7'h00;
      wait_ff <= 16'h0000;
    end else if (wait_ff != 16'h0000) begin
      wait_ff <= wait_ff - 16'h0001;
    end else if (code_ff != dest) begin
      // One LSB at a time, never a jump
      code_ff <= (dest > code_ff) ? code_ff + 7'h01 : code_ff - 7'h01;
      wait_ff <= gap;
    end
  end
  assign voltage_code = code_ff;
  assign busy = (code_ff != dest);
endmodule : bfv_cpu_model

/* File: bfv_supervisor_tb.sv */
`timescale 1ns/1ps
module bfv_supervisor_tb;
  import bfv_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  bfv_pins_t pins, pin_bus; // Pins from bench, bus with model code
  logic pwm_enable, low_side_mode_n, driver_off_n, ss_discharge;
  logic sec_current_limit_set_clamp, force_multi_phase, thermal_throttle_out;
  logic output_ok_mask;
  logic [6:0] ref_code, cpu_code, dest;
  logic [15:0] gap;
  int error_cnt, check_count, n;
  // Short counts keep the run small
  bfv_supervisor #(.CURRENT_LIMIT_SET_CYCLES(50), .MASK_CYCLES(300)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .pin_in(pin_bus), .pwm_enable(pwm_enable),
    .low_side_mode_n(low_side_mode_n), .driver_off_n(driver_off_n),
    .ss_discharge(ss_discharge), .sec_current_limit_set_clamp(sec_current_limit_set_clamp),
    .force_multi_phase(force_multi_phase),
    .thermal_throttle_out(thermal_throttle_out),
    .output_ok_mask(output_ok_mask), .ref_code(ref_code));
  bfv_cpu_model cpu (.hclk(hclk), .hresetn(hresetn), .dest(dest),
    .gap(gap), .voltage_code(cpu_code), .busy());
  // Single slave: its ready is the bus ready
  assign hready = hreadyout;
  always_comb begin
    pin_bus = pins;
    pin_bus.voltage_code = cpu_code;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  task tick(input int c);
    repeat (c) @(posedge hclk);
  endtask : tick
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One AHB single transfer; waits on hready, never a fixed count
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'b010;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb
  // Counts edges until the reference shows a value
  task wait_ref(input logic [6:0] v, output int c);
    c = 0;
    while (ref_code !== v && c < 9000) begin
      @(posedge hclk);
      c++;
    end
    chk(ref_code, v);
  endtask : wait_ref
  task recycle;
    pins.enable <= 1'b0;
    tick(8);
    pins.enable <= 1'b1;
    tick(8);
  endtask : recycle
  // Reverse-voltage trip, middle band, recovery
  task rvp_cycle(input logic after_lvl);
    pins.rvp_above <= 1'b0;
    pins.rvp_below <= 1'b1;
    tick(8);
    chk(pwm_enable, 1'b0);
    chk({driver_off_n, low_side_mode_n}, 2'b00);
    pins.rvp_below <= 1'b0;
    tick(8);
    chk(driver_off_n, 1'b0);
    pins.rvp_above <= 1'b1;
    tick(8);
    chk({driver_off_n, low_side_mode_n}, {2{after_lvl}});
  endtask : rvp_cycle
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_start;
    tick(8);
    chk({pwm_enable, driver_off_n, low_side_mode_n}, 3'b000);
    chk(ss_discharge, 1'b1);
    pins.supply_ok <= 1'b1;
    pins.out_low_cmp <= 1'b1;
    tick(8);
    chk(pwm_enable, 1'b0);
    pins.enable <= 1'b1;
    tick(8);
    chk({pwm_enable, ss_discharge}, 2'b10);
    chk(sec_current_limit_set_clamp, 1'b1);
    pins.out_low_cmp <= 1'b0;
    tick(8);
    chk(sec_current_limit_set_clamp, 1'b0);
  endtask : t_start
  task t_current_limit_set;
    pins.current_limit_set_cmp <= 1'b1;
    tick(30);
    pins.current_limit_set_cmp <= 1'b0;
    tick(6);
    pins.current_limit_set_cmp <= 1'b1;
    tick(40);
    chk(pwm_enable, 1'b1);
    tick(20);
    chk({pwm_enable, driver_off_n, low_side_mode_n}, 3'b000);
    pins.current_limit_set_cmp <= 1'b0;
    tick(20);
    ahb(1'b0, {24'h0000_00, REG_STATUS}, 32'h0000_0000);
    chk(rd[ST_CURRENT_LIMIT_SET_LATCH], 1'b1);
    chk(pwm_enable, 1'b0);
    recycle();
    chk(pwm_enable, 1'b1);
  endtask : t_current_limit_set
  task t_ovp;
    rvp_cycle(1'b1);
    pins.tt_grounded <= 1'b1;
    pins.ovp_cmp <= 1'b1;
    tick(8);
    chk(pwm_enable, 1'b1);
    pins.tt_grounded <= 1'b0;
    tick(8);
    chk({pwm_enable, driver_off_n, low_side_mode_n}, 3'b011);
    pins.ovp_cmp <= 1'b0;
    tick(8);
    chk({pwm_enable, driver_off_n}, 2'b01);
    rvp_cycle(1'b1);
    chk(pwm_enable, 1'b0);
    recycle();
    chk(pwm_enable, 1'b1);
    pins.tt_hot <= 1'b1;
    tick(8);
    chk(thermal_throttle_out, 1'b1);
    pins.tt_hot <= 1'b0;
    tick(8);
    chk(thermal_throttle_out, 1'b0);
  endtask : t_ovp
  task t_code;
    pins.single_phase_req <= 1'b1;
    tick(8);
    chk(force_multi_phase, 1'b0);
    dest <= 7'h02;
    tick(10);
    chk({force_multi_phase, output_ok_mask}, 2'b11);
    tick(40);
    chk(ref_code, 7'h00);
    wait_ref(7'h01, n);
    wait_ref(7'h02, n);
    chk(n, FAST_CYC);
    pins.deep_sleep_req <= 1'b1;
    dest <= 7'h04;
    wait_ref(7'h03, n);
    wait_ref(7'h04, n);
    chk(n, SLOW_CYC);
    pins.deep_sleep_req <= 1'b0;
    ahb(1'b1, {24'h0000_00, REG_CTRL}, 32'h0000_0001);
    ahb(1'b0, {24'h0000_00, REG_CTRL}, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    dest <= 7'h06;
    wait_ref(7'h05, n);
    wait_ref(7'h06, n);
    chk(n, SLOW_CYC);
    ahb(1'b1, {24'h0000_00, REG_CTRL}, 32'h0000_0000);
    tick(400);
    chk(output_ok_mask, 1'b0);
    dest <= 7'h07;
    tick(200);
    dest <= 7'h08;
    tick(250);
    chk(output_ok_mask, 1'b1);
    tick(100);
    chk(output_ok_mask, 1'b0);
    wait_ref(7'h08, n);
    ahb(1'b0, {24'h0000_00, REG_CODE}, 32'h0000_0000);
    chk(rd, {CODE_TOP_MV10 - 16'h0008 * CODE_STEP_MV10, 16'h0808});
    gap <= 16'h005A;
    dest <= 7'h78;
    tick(11000);
    ahb(1'b0, {24'h0000_00, REG_CODE}, 32'h0000_0000);
    chk({rd[31:16], 9'h000, rd[6:0]}, 32'h0000_0078);
    ahb(1'b0, 32'h0000_0010, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(hresp, 1'b0);
  endtask : t_code
  // ----------------------------------------------------------------
  // Verdict and main sequence
  // ----------------------------------------------------------------
  task results;
    if (error_cnt == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  // Expected run is near 16k cycles; this allows about twice that
  initial begin
    #150_000;
    error_cnt++;
    results();
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0000_0000;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    pins = '0;
    pins.rvp_above = 1'b1;
    dest = 7'h00;
    gap = 16'h000A;
    error_cnt = 0;
    check_count = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_start();
    t_current_limit_set();
    t_ovp();
    t_code();
    results();
  end
endmodule : bfv_supervisor_tb
